// File: shared/ppfs_pkg.sv
// Package for the port pin function select block.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
`default_nettype none
package ppfs_pkg;
  // ******************************************************************
  // Register byte offsets
  // ******************************************************************
  localparam logic [7:0] PB_LAT_OFF   = 8'h00;
  localparam logic [7:0] PB_DIR_OFF   = 8'h04;
  localparam logic [7:0] PC_LAT_OFF   = 8'h08;
  localparam logic [7:0] PC_DIR_OFF   = 8'h0C;
  localparam logic [7:0] PULL_EN_OFF  = 8'h10;
  localparam logic [7:0] WAKE_EN_OFF  = 8'h14;
  localparam logic [7:0] CTRL_OFF     = 8'h18;
  localparam logic [7:0] STATUS_OFF   = 8'h1C;
  localparam logic [7:0] WAKE_FLG_OFF = 8'h20;
  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int CTRL_INSTRUCTION_CLOCK_OUT_BIT = 0;
  localparam int CTRL_TMRCLK_BIT = 1;
  localparam int ST_PC_LSB       = 8;
  localparam int ST_WAKE_BIT     = 16;
  localparam int ST_OSC_LSB      = 20;
  localparam int ST_MASTER_CLEAR_N_BIT     = 23;
  localparam int ST_PROG_BIT     = 24;
  localparam logic [5:0] PORT_RST = 6'h00;
  localparam logic [5:0] DIR_RST  = 6'h00;  // All inputs after reset
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Pins 0, 1, 3, 4 carry pull-up and wake-on-change
  localparam logic [5:0] PULL_WAKE_MASK = 6'h1B;
  // ******************************************************************
  // Oscillator mode codes on the configuration input
  // ******************************************************************
  localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'h0;
  localparam logic [2:0] STANDARD_CRYSTAL_MODE  = 3'h1;
  localparam logic [2:0] HIGH_SPEED_CRYSTAL_MODE = 3'h2;
  localparam logic [2:0] INTERNAL_RC_OSC_MODE   = 3'h3;
  localparam logic [2:0] EXTERNAL_RC_OSC_MODE   = 3'h4;
  // Instruction clock is the oscillator divided by this
  localparam int INSTR_CLK_DIV = 4;
endpackage
`default_nettype wire

// File: hw/ppfs_pin_mux.sv
// Pin function multiplexer for port B and port C of a small controller.
// Assumes i_clk is the oscillator input clock and straps are stable.
//
// Function
// - Pin zero: port bit or programming data
// - Pin one: port bit or programming clock
// - Schmitt buffers on programming pins, else TTL
// - Pins 0,1,3,4: pull-up and wake enables
// - Pin three is active-low reset when configured
// - Pin three input-only; pull-up port mode only
// - Low-power and standard crystal modes give pin four to oscillator
// - RC modes may output quarter-rate instruction clock
// - Pin five port only in internal RC
// - Pin five TTL as port, Schmitt external RC
// - Port C pin five: port or timer clock
`default_nettype none
module ppfs_pin_mux (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Configuration straps and programming engine
  input  wire logic [2:0]  i_osc_mode,
  input  wire logic        i_master_clear_n_en,
  input  wire logic        i_prog_mode,
  input  wire logic        i_prog_data_out,
  input  wire logic        i_prog_data_oe,
  output logic             o_prog_data_in,
  output logic             o_prog_clk_in,
  // Port pins
  input  wire logic [5:0]  i_pb_in,
  output logic      [5:0]  o_pb_out,
  output logic      [5:0]  o_pb_oe,
  output logic      [5:0]  o_pb_pullup,
  output logic      [5:0]  o_pb_schmitt,
  input  wire logic [5:0]  i_pc_in,
  output logic      [5:0]  o_pc_out,
  output logic      [5:0]  o_pc_oe,
  output logic      [5:0]  o_pc_schmitt,
  // Special functions
  output logic             o_master_clear_n,
  output logic             o_oscillator_output_sel,
  output logic             o_oscillator_input_sel,
  output logic             o_timer_external_clock_in,
  output logic             o_wake
);
  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  logic [12:0] sync1_q, sync2_q;
  logic [5:0]  pb_s, pc_s;
  logic        prog_s;
  assign pb_s   = sync2_q[5:0];
  assign pc_s   = sync2_q[11:6];
  assign prog_s = sync2_q[12];

  // Two flops per pin; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 13'h0000;
      sync2_q <= 13'h0000;
    end else begin
      sync1_q <= {i_prog_mode, i_pc_in, i_pb_in};
      sync2_q <= sync1_q;
    end
  end

  // ******************************************************************
  // Configuration capture
  // ******************************************************************
  logic       cfg_done_q, cfg_done_d;
  logic [2:0] osc_q, osc_d;
  logic       master_clear_n_q, master_clear_n_d;

  // Straps caught on the first edge after reset, then frozen
  always_comb begin
    cfg_done_d = 1'b1;
    osc_d      = cfg_done_q ? osc_q : i_osc_mode;
    master_clear_n_d     = cfg_done_q ? master_clear_n_q : i_master_clear_n_en;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_done_q <= 1'b0;
      osc_q      <= ppfs_pkg::INTERNAL_RC_OSC_MODE;
      master_clear_n_q     <= 1'b0;
    end else begin
      cfg_done_q <= cfg_done_d;
      osc_q      <= osc_d;
      master_clear_n_q     <= master_clear_n_d;
    end
  end

  logic crystal, rc_mode, internal_rc_osc_mode, external_rc_osc_mode;
  assign crystal = (osc_q == ppfs_pkg::STANDARD_CRYSTAL_MODE) ||
                   (osc_q == ppfs_pkg::LOW_POWER_CRYSTAL_MODE);
  assign internal_rc_osc_mode   = (osc_q == ppfs_pkg::INTERNAL_RC_OSC_MODE);
  assign external_rc_osc_mode   = (osc_q == ppfs_pkg::EXTERNAL_RC_OSC_MODE);
  assign rc_mode = internal_rc_osc_mode || external_rc_osc_mode;

  // ******************************************************************
  // Register file and Wishbone slave
  // ******************************************************************
  logic [5:0]  pb_lat_q, pb_lat_d, pb_dir_q, pb_dir_d;
  logic [5:0]  pc_lat_q, pc_lat_d, pc_dir_q, pc_dir_d;
  logic [5:0]  pull_q, pull_d, wake_en_q, wake_en_d;
  logic [5:0]  wflg_q, wflg_d, prev_q;
  logic [1:0]  ctrl_q, ctrl_d;
  logic        ack_d;
  logic [31:0] rdat_d, status;
  logic        wr, lane0;
  logic [5:0]  change;

  assign wr     = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign lane0  = i_wb_sel[0];
  // Only wake-enabled pins 0, 1, 3, 4 can flag a change
  assign change = (pb_s ^ prev_q) & wake_en_q
                  & ppfs_pkg::PULL_WAKE_MASK;

  always_comb begin
    status = 32'h0000_0000;
    status[5:0] = pb_s;
    status[ppfs_pkg::ST_PC_LSB +: 6]  = pc_s;
    status[ppfs_pkg::ST_WAKE_BIT]     = |wflg_q;
    status[ppfs_pkg::ST_OSC_LSB +: 3] = osc_q;
    status[ppfs_pkg::ST_MASTER_CLEAR_N_BIT]     = master_clear_n_q;
    status[ppfs_pkg::ST_PROG_BIT]     = prog_s;
  end

  // Writes land on the edge the master sees ack; one-cycle ack
  always_comb begin
    pb_lat_d  = pb_lat_q;
    pb_dir_d  = pb_dir_q;
    pc_lat_d  = pc_lat_q;
    pc_dir_d  = pc_dir_q;
    pull_d    = pull_q;
    wake_en_d = wake_en_q;
    ctrl_d    = ctrl_q;
    wflg_d    = wflg_q;
    if (wr && lane0) begin
      case (i_wb_adr)
        ppfs_pkg::PB_LAT_OFF:  pb_lat_d  = i_wb_dat[5:0];
        ppfs_pkg::PB_DIR_OFF:  pb_dir_d  = i_wb_dat[5:0];
        ppfs_pkg::PC_LAT_OFF:  pc_lat_d  = i_wb_dat[5:0];
        ppfs_pkg::PC_DIR_OFF:  pc_dir_d  = i_wb_dat[5:0];
        ppfs_pkg::PULL_EN_OFF: pull_d    = i_wb_dat[5:0];
        ppfs_pkg::WAKE_EN_OFF: wake_en_d = i_wb_dat[5:0];
        ppfs_pkg::CTRL_OFF:    ctrl_d    = i_wb_dat[1:0];
        ppfs_pkg::WAKE_FLG_OFF: wflg_d   = wflg_q & ~i_wb_dat[5:0];
        default: ;
      endcase
    end
    // A change in the clearing cycle still sets its flag
    wflg_d = wflg_d | change;
    ack_d  = i_wb_cyc && i_wb_stb && !o_wb_ack;
    rdat_d = 32'h0000_0000;
    case (i_wb_adr)
      ppfs_pkg::PB_LAT_OFF:   rdat_d[5:0] = pb_lat_q;
      ppfs_pkg::PB_DIR_OFF:   rdat_d[5:0] = pb_dir_q;
      ppfs_pkg::PC_LAT_OFF:   rdat_d[5:0] = pc_lat_q;
      ppfs_pkg::PC_DIR_OFF:   rdat_d[5:0] = pc_dir_q;
      ppfs_pkg::PULL_EN_OFF:  rdat_d[5:0] = pull_q;
      ppfs_pkg::WAKE_EN_OFF:  rdat_d[5:0] = wake_en_q;
      ppfs_pkg::CTRL_OFF:     rdat_d[1:0] = ctrl_q;
      ppfs_pkg::STATUS_OFF:   rdat_d      = status;
      ppfs_pkg::WAKE_FLG_OFF: rdat_d[5:0] = wflg_q;
      default:                rdat_d      = 32'h0000_0000;
    endcase
    if (!ack_d || i_wb_we) begin
      rdat_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pb_lat_q  <= ppfs_pkg::PORT_RST;
      pb_dir_q  <= ppfs_pkg::DIR_RST;
      pc_lat_q  <= ppfs_pkg::PORT_RST;
      pc_dir_q  <= ppfs_pkg::DIR_RST;
      pull_q    <= ppfs_pkg::PORT_RST;
      wake_en_q <= ppfs_pkg::PORT_RST;
      ctrl_q    <= ppfs_pkg::CTRL_RST;
      wflg_q    <= ppfs_pkg::PORT_RST;
      prev_q    <= ppfs_pkg::PORT_RST;
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
    end else begin
      pb_lat_q  <= pb_lat_d;
      pb_dir_q  <= pb_dir_d;
      pc_lat_q  <= pc_lat_d;
      pc_dir_q  <= pc_dir_d;
      pull_q    <= pull_d;
      wake_en_q <= wake_en_d;
      ctrl_q    <= ctrl_d;
      wflg_q    <= wflg_d;
      prev_q    <= pb_s;
      o_wb_ack  <= ack_d;
      o_wb_dat  <= rdat_d;
    end
  end

  // ******************************************************************
  // Instruction clock divider
  // ******************************************************************
  logic [1:0] div_q, div_d;
  // Wraps every INSTR_CLK_DIV cycles; top bit is a 50 % square wave
  always_comb begin
    div_d = (32'(div_q) == ppfs_pkg::INSTR_CLK_DIV - 1) ? 2'h0
                                                        : div_q + 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // ******************************************************************
  // Pin function selection
  // ******************************************************************
  logic [5:0] pbo_d, pboe_d, pbpu_d, pbst_d, pco_d, pcoe_d, pcst_d;
  logic       master_clear_n_n_d, osc_out_d, osc_in_d, tmr_d, pdi_d, pci_d;
  logic       instruction_clock_out_on;
  assign instruction_clock_out_on = rc_mode && ctrl_q[ppfs_pkg::CTRL_INSTRUCTION_CLOCK_OUT_BIT];

  // Registered so that pins never glitch between functions
  always_comb begin
    pbo_d  = pb_lat_q;
    pboe_d = pb_dir_q;
    pbpu_d = pull_q & ppfs_pkg::PULL_WAKE_MASK;
    pbst_d = 6'h00;
    pdi_d  = 1'b0;
    pci_d  = 1'b0;
    if (prog_s) begin
      pbo_d[0]  = i_prog_data_out;
      pboe_d[0] = i_prog_data_oe;
      pboe_d[1] = 1'b0;
      pbst_d[1:0] = 2'h3;
      pdi_d = pb_s[0];
      pci_d = pb_s[1];
    end
    pboe_d[3] = 1'b0;
    pbo_d[3]  = 1'b0;
    master_clear_n_n_d  = 1'b1;
    if (master_clear_n_q) begin
      pbpu_d[3] = 1'b0;
      pbst_d[3] = 1'b1;
      master_clear_n_n_d  = pb_s[3];
    end
    osc_out_d = crystal;
    if (crystal) begin
      pboe_d[4] = 1'b0;
      pbo_d[4]  = 1'b0;
      pbpu_d[4] = 1'b0;
    end else if (instruction_clock_out_on) begin
      pboe_d[4] = 1'b1;
      pbo_d[4]  = div_q[1];
    end
    osc_in_d = !internal_rc_osc_mode;
    if (!internal_rc_osc_mode) begin
      pboe_d[5] = 1'b0;
      pbo_d[5]  = 1'b0;
    end
    pbst_d[5] = external_rc_osc_mode;
    pco_d  = pc_lat_q;
    pcoe_d = pc_dir_q;
    pcst_d = 6'h20;
    tmr_d  = 1'b0;
    if (ctrl_q[ppfs_pkg::CTRL_TMRCLK_BIT]) begin
      pcoe_d[5] = 1'b0;
      tmr_d     = pc_s[5];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pb_out     <= 6'h00;
      o_pb_oe      <= 6'h00;
      o_pb_pullup  <= 6'h00;
      o_pb_schmitt <= 6'h00;
      o_pc_out     <= 6'h00;
      o_pc_oe      <= 6'h00;
      o_pc_schmitt <= 6'h00;
      o_master_clear_n          <= 1'b1;
      o_oscillator_output_sel   <= 1'b0;
      o_oscillator_input_sel    <= 1'b0;
      o_timer_external_clock_in <= 1'b0;
      o_prog_data_in <= 1'b0;
      o_prog_clk_in  <= 1'b0;
      o_wake         <= 1'b0;
    end else begin
      o_pb_out     <= pbo_d;
      o_pb_oe      <= pboe_d;
      o_pb_pullup  <= pbpu_d;
      o_pb_schmitt <= pbst_d;
      o_pc_out     <= pco_d;
      o_pc_oe      <= pcoe_d;
      o_pc_schmitt <= pcst_d;
      o_master_clear_n          <= master_clear_n_n_d;
      o_oscillator_output_sel   <= osc_out_d;
      o_oscillator_input_sel    <= osc_in_d;
      o_timer_external_clock_in <= tmr_d;
      o_prog_data_in <= pdi_d;
      o_prog_clk_in  <= pci_d;
      o_wake         <= |wflg_q;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  pin3_no_drive_a: assert property (!o_pb_oe[3])
    else $error("pin three driven");
  cfg_frozen_a: assert property (cfg_done_q |=> $stable(osc_q) && $stable(master_clear_n_q))
    else $error("config changed after reset");
  prog_schmitt_a: assert property (prog_s |=> o_pb_schmitt[1:0] == 2'h3)
    else $error("programming pins not schmitt");
  prog_data_a: assert property (prog_s && i_prog_data_oe |=> o_pb_oe[0])
    else $error("programming data not driven");
  prog_clk_a: assert property (prog_s |=> !o_pb_oe[1] && o_prog_clk_in == $past(pb_s[1]))
    else $error("programming clock wrong");
  master_clear_n_follow_a: assert property (master_clear_n_q |=> o_master_clear_n == $past(pb_s[3]) && !o_pb_pullup[3])
    else $error("master clear not following pin");
  crystal_pin4_a: assert property (crystal |=> !o_pb_oe[4] && o_oscillator_output_sel)
    else $error("pin four not given to crystal");
  instruction_clock_out_rate_a: assert property (instruction_clock_out_on && $rose(div_q[1]) |-> ##2 $fell(div_q[1]) ##2 $rose(div_q[1]))
    else $error("instruction clock not quarter rate");
  pin5_osc_a: assert property (!internal_rc_osc_mode |=> !o_pb_oe[5] && o_oscillator_input_sel)
    else $error("pin five not oscillator input");
  pin5_buf_a: assert property (##1 o_pb_schmitt[5] == $past(external_rc_osc_mode))
    else $error("pin five buffer wrong");
  wake_set_a: assert property (change[0] |=> wflg_q[0] ##1 o_wake)
    else $error("wake flag lost");
  tmr_pin_a: assert property (ctrl_q[ppfs_pkg::CTRL_TMRCLK_BIT] |=> !o_pc_oe[5] && o_pc_schmitt[5])
    else $error("timer clock pin driven");

  prog_cov: cover property (prog_s ##1 o_pb_oe[0]);
  instruction_clock_out_cov: cover property (instruction_clock_out_on ##4 o_pb_out[4]);
  wake_cov: cover property (change != 6'h00 ##2 o_wake);
endmodule
`default_nettype wire

// File: dv/ppfs_board.sv
// Board model: external pin drivers, weak pull-ups and floating pins.
// Assumes the bench sets per-pin external drive values and enables.
`default_nettype none
module ppfs_board (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_pb_out,
  input  wire logic [5:0] i_pb_oe,
  input  wire logic [5:0] i_pb_pullup,
  input  wire logic [5:0] i_pc_out,
  input  wire logic [5:0] i_pc_oe,
  input  wire logic [5:0] i_pb_ext,
  input  wire logic [5:0] i_pb_ext_en,
  input  wire logic [5:0] i_pc_ext,
  input  wire logic [5:0] i_pc_ext_en,
  output logic      [5:0] o_pb_lvl,
  output logic      [5:0] o_pc_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Pin level resolution
  // ****************************************************************
  logic [5:0] pb_last_q;
  logic [5:0] pc_last_q;
  // Device wins, then board drive (programmer on pins 0 and 1), then port B
  // pull-up (port C has none); a floating pin toggles so no stale value can pass
  assign o_pb_lvl = (i_pb_oe & i_pb_out) | (~i_pb_oe & ((i_pb_ext_en &
    i_pb_ext) | (~i_pb_ext_en & (i_pb_pullup | ~pb_last_q))));
  assign o_pc_lvl = (i_pc_oe & i_pc_out) | (~i_pc_oe & ((i_pc_ext_en &
    i_pc_ext) | (~i_pc_ext_en & ~pc_last_q)));
  // Last level, used only for the floating pattern
  always_ff @(posedge i_clk) begin
    pb_last_q <= o_pb_lvl;
    pc_last_q <= o_pc_lvl;
  end
endmodule
`default_nettype wire

// File: dv/ppfs_pin_mux_tb.sv
// Self-checking bench for the pin function multiplexer.
// Assumes the board model beside the design; straps change in reset.
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module ppfs_pin_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals, clock and bus task
  // ****************************************************************
  logic        clk, nrst, cyc, stb, we, ack, master_clear_n, pmode, pdo, pdoe;
  logic        pclk_in, pdin, mc_n, osel, isel, tmr, wake;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [2:0]  osc;
  logic [5:0]  pb_lvl, pc_lvl, pb_out, pb_oe, pb_pu, pb_st;
  logic [5:0]  pc_out, pc_oe, pc_st, pb_ext, pb_en, pc_ext, pc_en;
  logic [7:0]  s;
  int          errors, num_checks;
  ppfs_pin_mux dut (.i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_osc_mode(osc),
    .i_master_clear_n_en(master_clear_n), .i_prog_mode(pmode), .i_prog_data_out(pdo),
    .i_prog_data_oe(pdoe), .o_prog_data_in(pdin), .o_prog_clk_in(pclk_in),
    .i_pb_in(pb_lvl), .o_pb_out(pb_out), .o_pb_oe(pb_oe),
    .o_pb_pullup(pb_pu), .o_pb_schmitt(pb_st), .i_pc_in(pc_lvl),
    .o_pc_out(pc_out), .o_pc_oe(pc_oe), .o_pc_schmitt(pc_st),
    .o_master_clear_n(mc_n), .o_oscillator_output_sel(osel),
    .o_oscillator_input_sel(isel), .o_timer_external_clock_in(tmr),
    .o_wake(wake));
  ppfs_board board (.i_clk(clk), .i_pb_out(pb_out), .i_pb_oe(pb_oe),
    .i_pb_pullup(pb_pu), .i_pc_out(pc_out), .i_pc_oe(pc_oe),
    .i_pb_ext(pb_ext), .i_pb_ext_en(pb_en), .i_pc_ext(pc_ext),
    .i_pc_ext_en(pc_en), .o_pb_lvl(pb_lvl), .o_pc_lvl(pc_lvl));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Classic single cycle; read data lands in rd at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) errors++;
  endtask
  // Straps are only caught on leaving reset, so set them inside it
  task automatic rst(input logic [2:0] m, input logic c);
    @(posedge clk);
    nrst <= 1'b0;
    osc <= m;
    master_clear_n <= c;
    repeat (6) @(posedge clk);
    `CHK("rst_oe", 6'h00, pb_oe)
    `CHK("rst_mc", 1'b1, mc_n)
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every oscillator mode; straps flipped after reset must not matter
  task automatic t_modes;
    logic c, x;
    for (int m = 0; m < 5; m++) begin
      c = m[0];
      x = (m < 2);
      rst(m[2:0], c);
      osc <= 3'h3 ^ m[2:0];
      master_clear_n <= ~c;
      wb(1'b1, ppfs_pkg::PULL_EN_OFF, 32'h0000_003F);
      repeat (3) @(posedge clk);
      `CHK("osel", x, osel)
      `CHK("isel", (m != 3), isel)
      if (m == 4) `CHK("st5", 1'b1, pb_st[5])
      if (m == 3) `CHK("st5", 1'b0, pb_st[5])
      `CHK("pull", 6'h1B & ~{1'b0, x, c, 3'h0}, pb_pu)
      if (c) `CHK("st3", 1'b1, pb_st[3])
      wb(1'b0, ppfs_pkg::STATUS_OFF, 32'h0000_0000);
      `CHK("st_osc", m[2:0], rd[22:20])
      `CHK("st_master_clear_n", c, rd[23])
      pb_ext[3] <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("mc_hi", 1'b1, mc_n)
      pb_ext[3] <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("mc_lo", ~c, mc_n)
    end
    $display("test modes done");
  endtask
  // Port drive; pin three never driven, unmapped place reads zero
  task automatic t_port;
    wb(1'b1, ppfs_pkg::PB_DIR_OFF, 32'h0000_003F);
    wb(1'b1, ppfs_pkg::PB_LAT_OFF, 32'h0000_002A);
    wb(1'b1, ppfs_pkg::PC_DIR_OFF, 32'h0000_003F);
    wb(1'b1, ppfs_pkg::PC_LAT_OFF, 32'h0000_0015);
    repeat (4) @(posedge clk);
    `CHK("pb_oe", 6'h37, pb_oe)
    `CHK("pb_out", 6'h22, pb_out & 6'h37)
    `CHK("pc_drv", 12'hFD5, {pc_oe, pc_out})
    wb(1'b0, ppfs_pkg::STATUS_OFF, 32'h0000_0000);
    `CHK("pins", 14'h1522, rd[13:0])
    wb(1'b1, ppfs_pkg::PB_DIR_OFF, 32'h0000_0000);
    wb(1'b1, ppfs_pkg::PC_DIR_OFF, 32'h0000_0000);
    wb(1'b0, ppfs_pkg::PB_LAT_OFF, 32'h0000_0000);
    `CHK("lat", 32'h0000_002A, rd)
    wb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmap", 32'h0000_0000, rd)
    $display("test port done");
  endtask
  // Wake on change: pin two has none, pin zero does, flag clears
  task automatic t_wake;
    wb(1'b1, ppfs_pkg::WAKE_EN_OFF, 32'h0000_003F);
    wb(1'b1, ppfs_pkg::WAKE_FLG_OFF, 32'h0000_003F);
    repeat (4) @(posedge clk);
    `CHK("wake0", 1'b0, wake)
    pb_ext <= 6'h04;
    repeat (6) @(posedge clk);
    `CHK("wake2", 1'b0, wake)
    pb_ext <= 6'h05;
    repeat (6) @(posedge clk);
    `CHK("wake1", 1'b1, wake)
    wb(1'b0, ppfs_pkg::WAKE_FLG_OFF, 32'h0000_0000);
    `CHK("flags", 32'h0000_0001, rd)
    wb(1'b1, ppfs_pkg::WAKE_FLG_OFF, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `CHK("wake_clr", 1'b0, wake)
    $display("test wake done");
  endtask
  // Instruction clock on pin four: two high, two low
  task automatic t_instruction_clock_out;
    wb(1'b1, ppfs_pkg::CTRL_OFF, 32'h0000_0001);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      s[i] = pb_out[4];
    end
    `CHK("ck_oe", 1'b1, pb_oe[4])
    for (int i = 0; i < 6; i++) `CHK("ck_ph", ~s[i], s[i+2])
    wb(1'b1, ppfs_pkg::CTRL_OFF, 32'h0000_0000);
    $display("test instruction_clock_out done");
  endtask
  // Programming mode: Schmitt buffers, clock in, data both ways
  task automatic t_prog;
    pmode <= 1'b1;
    pb_ext <= 6'h03;
    repeat (6) @(posedge clk);
    `CHK("pg_st", 2'b11, pb_st[1:0])
    `CHK("pg_ck", 1'b1, pclk_in)
    `CHK("pg_din", 1'b1, pdin)
    `CHK("pg_ckoe", 1'b0, pb_oe[1])
    pdoe <= 1'b1;
    pb_ext <= 6'h01;
    repeat (4) @(posedge clk);
    `CHK("pg_doe", 2'b10, {pb_oe[0], pb_out[0]})
    `CHK("pg_ck0", 1'b0, pclk_in)
    pdoe <= 1'b0;
    pmode <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("pg_ttl", 2'b00, pb_st[1:0])
    $display("test prog done");
  endtask
  // Port C pin five as timer clock input
  task automatic t_timer;
    wb(1'b1, ppfs_pkg::CTRL_OFF, 32'h0000_0002);
    pc_ext <= 6'h20;
    repeat (5) @(posedge clk);
    `CHK("tmr1", 1'b1, tmr)
    `CHK("tmr_st", 1'b1, pc_st[5])
    pc_ext <= 6'h00;
    repeat (5) @(posedge clk);
    `CHK("tmr0", 1'b0, tmr)
    $display("test timer done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence, all inputs defined at time zero
  initial begin
    {cyc, stb, we, adr, wdat, master_clear_n, pmode, pdo, pdoe, nrst} = '0;
    {pb_ext, pc_ext, errors, num_checks} = '0;
    {osc, pb_en, pc_en} = {3'h3, 12'hFFF};
    t_modes();
    rst(3'h3, 1'b0);
    t_port();
    t_wake();
    t_instruction_clock_out();
    t_prog();
    t_timer();
    final_report();
  end
  // Watchdog at 4000 cycles, far beyond the few hundred cycles expected
  initial begin
    #20000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
